// [rtl/alr_ctrl.sv]
// Purpose: Register front end for a 10-bit converter, 8-tap level detector and audio recorder
// Assumes: All inputs synchronous to clk; analog macro samples conv_clk_q while converting
// Notes:   Read data appear in the cycle after the read strobe only
//
// Functional notes
// - Interrupt enables at bits 22 and 21
// - Bit 19 detector pending, write 0 clears
// - Bit 18 conversion pending, write 0 clears
// - Bit 17 block enable, bit 16 block reset
// - Start bit set by software, hardware clears
// - Result read restarts conversion when bit 12
// - Channel field 11:9 selects inputs 2-7
// - Recording uses inputs 0/1, ignores channel
// - Finish bit 0 low while converting
// - Result in bits 9:0, upper zero
// - Detector control bit 3 enables detector
// - Tap field closes exactly one switch
// - Status bit 0 high below reference
// - Interval field sets samples per flag
// - Audio flag set while recording, write 0 clears
// - Bit 8 enables gain and record paths
// - Gain field sets 0-31 dB
// - Bit 2 inserts high-pass filter
// - Bit 1 enables decimation filter, recording
// - Bit 0 holds digital filter reset
// - Four buffer words, two samples each
// - Conversion takes 50 converter clocks
// - Disabled block stops clock, keeps result
// - No normal conversions while recording
`default_nettype none

module alr_ctrl
  import alr_pkg::*;
#(
  parameter int unsigned CONV_DIV = CONV_DIV_DEF
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata_q,
  output logic                   irq_q,
  output logic                   conv_enable_q,
  output logic                   conv_reset_q,
  output logic                   conv_clk_q,
  output logic                   conv_start_q,
  output logic      [2:0]        conv_channel_q,
  input  wire logic [RESULT_W-1:0] conv_data,
  output logic                   detector_enable_q,
  output logic      [DET_TAPS-1:0] detector_switch_q,
  input  wire logic              detector_below_ref,
  output logic                   gain_path_enable_q,
  output logic      [4:0]        record_gain_db_q,
  output logic                   highpass_enable_q,
  output logic                   decim_enable_q,
  output logic                   filter_reset_q,
  input  wire logic              rec_sample_valid,
  input  wire logic [SAMPLE_W-1:0] rec_sample
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CONV_DIV < 2 || CONV_DIV > 255)
  begin : g_bad_div
    $error("CONV_DIV must lie in 2..255");
  end

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } alr_state_e;

  alr_state_e          state_q;
  logic                det_irq_en_q;
  logic                conv_irq_en_q;
  logic                det_irq_q;
  logic                conv_irq_q;
  logic                conv_en_q;
  logic                conv_rst_q;
  logic                start_q;
  logic                restart_rd_q;
  logic [2:0]          chan_q;
  logic                finish_q;
  logic                kick_q;
  logic [RESULT_W-1:0] result_q;
  logic [7:0]          div_cnt_q;
  logic [5:0]          cyc_cnt_q;
  logic                det_en_q;
  logic [2:0]          tap_q;
  logic [1:0]          aud_intv_q;
  logic [3:0]          eng_ofs_q;
  logic                aud_irq_q;
  logic                gain_en_q;
  logic [4:0]          gain_q;
  logic                hp_en_q;
  logic                decim_en_q;
  logic                filt_rst_q;
  logic [SAMPLE_W-1:0] samples_q [SAMPLE_SLOTS];
  logic [2:0]          wr_ptr_q;
  logic [3:0]          aud_cnt_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic wr_conv_ctrl;
  logic wr_det_ctrl;
  logic wr_aud_ctrl;
  logic rd_result;
  logic rec_active;
  logic conv_ok;
  logic go;
  logic div_end;
  logic conv_done;
  logic aud_take;
  logic aud_intv_hit;
  logic [3:0] aud_intv_n;

  assign wr_conv_ctrl = reg_wr && (reg_addr == OFS_CONV_CTRL);
  assign wr_det_ctrl  = reg_wr && (reg_addr == OFS_DET_CTRL);
  assign wr_aud_ctrl  = reg_wr && (reg_addr == OFS_AUDIO_CTRL);
  assign rd_result    = reg_rd && (reg_addr == OFS_CONV_RESULT);
  // Recording owns the converter while the decimation filter runs
  assign rec_active   = decim_en_q && !filt_rst_q;
  assign conv_ok      = conv_en_q && !conv_rst_q && !rec_active;
  assign go           = (state_q == ST_IDLE) && conv_ok && (start_q || kick_q);
  assign div_end      = div_cnt_q == 8'(CONV_DIV - 1);
  assign conv_done    = (state_q == ST_BUSY) && conv_ok && div_end
                        && (cyc_cnt_q == 6'(CONV_CYCLES - 1));
  assign aud_take     = rec_active && gain_en_q && rec_sample_valid;
  assign aud_intv_n   = 4'h1 << aud_intv_q;
  assign aud_intv_hit = aud_take && ((aud_cnt_q + 4'h1) == aud_intv_n);

  // ----------------------------------------------------------------
  // Converter control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      det_irq_en_q  <= 1'b0;
      conv_irq_en_q <= 1'b0;
      conv_en_q     <= 1'b0;
      conv_rst_q    <= 1'b0;
      restart_rd_q  <= 1'b0;
      chan_q        <= 3'h0;
    end
    else if (wr_conv_ctrl)
    begin
      det_irq_en_q  <= reg_wdata[BIT_DET_IRQ_EN];
      conv_irq_en_q <= reg_wdata[BIT_CONV_IRQ_EN];
      conv_en_q     <= reg_wdata[BIT_CONV_EN];
      conv_rst_q    <= reg_wdata[BIT_CONV_RST];
      restart_rd_q  <= reg_wdata[BIT_RESTART_RD];
      chan_q        <= reg_wdata[CHAN_LSB +: 3];
    end
  end

  // Pending bits: a hardware set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      det_irq_q  <= 1'b0;
      conv_irq_q <= 1'b0;
    end
    else
    begin
      if (det_en_q && detector_below_ref)
        det_irq_q <= 1'b1;
      else if (wr_conv_ctrl && !reg_wdata[BIT_DET_IRQ])
        det_irq_q <= 1'b0;
      if (conv_done)
        conv_irq_q <= 1'b1;
      else if (wr_conv_ctrl && !reg_wdata[BIT_CONV_IRQ])
        conv_irq_q <= 1'b0;
    end
  end

  // Start bit: software may only set it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      start_q <= 1'b0;
    else if (conv_done || conv_rst_q)
      start_q <= 1'b0;
    else if (wr_conv_ctrl && reg_wdata[BIT_CONV_START])
      start_q <= 1'b1;
  end

  // Result read restart, held until the converter can take it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      kick_q <= 1'b0;
    else if (rd_result && restart_rd_q && !rec_active)
      kick_q <= 1'b1;
    else if (go || conv_rst_q)
      kick_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q   <= ST_IDLE;
      div_cnt_q <= 8'h00;
      cyc_cnt_q <= 6'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          div_cnt_q <= 8'h00;
          cyc_cnt_q <= 6'h00;
          if (go)
            state_q <= ST_BUSY;
        end
        ST_BUSY:
        begin
          // Disable, reset or recording abandons the conversion
          if (!conv_ok || conv_done)
            state_q <= ST_IDLE;
          div_cnt_q <= div_end ? 8'h00 : div_cnt_q + 8'h01;
          if (div_end)
            cyc_cnt_q <= cyc_cnt_q + 6'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Result survives disable; only a finished conversion replaces it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      result_q <= '0;
      finish_q <= 1'b0;
    end
    else if (conv_done)
    begin
      result_q <= conv_data;
      finish_q <= 1'b1;
    end
    else if (go)
      finish_q <= 1'b0;
  end

  // Converter-side pins; clock runs only during a conversion
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      conv_enable_q  <= 1'b0;
      conv_reset_q   <= 1'b0;
      conv_clk_q     <= 1'b0;
      conv_start_q   <= 1'b0;
      conv_channel_q <= 3'h0;
    end
    else
    begin
      conv_enable_q  <= conv_en_q;
      conv_reset_q   <= conv_rst_q;
      conv_clk_q     <= (state_q == ST_BUSY) && !conv_done && conv_ok
                        && (div_cnt_q < 8'(CONV_DIV / 2));
      conv_start_q   <= go;
      conv_channel_q <= rec_active ? CHAN_AUDIO_PAIR : chan_q;
    end
  end

  // ----------------------------------------------------------------
  // Level detector
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      det_en_q <= 1'b0;
      tap_q    <= 3'h0;
    end
    else if (wr_det_ctrl)
    begin
      det_en_q <= reg_wdata[BIT_DET_EN];
      tap_q    <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      detector_enable_q <= 1'b0;
    else
      detector_enable_q <= det_en_q;
  end

  for (genvar t = 0; t < DET_TAPS; t++)
  begin : g_tap
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        detector_switch_q[t] <= 1'b0;
      else
        detector_switch_q[t] <= (tap_q == 3'(t));
    end
  end

  // ----------------------------------------------------------------
  // Audio record control
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aud_intv_q <= 2'h0;
      eng_ofs_q  <= 4'h0;
      gain_en_q  <= 1'b0;
      gain_q     <= 5'h00;
      hp_en_q    <= 1'b0;
      decim_en_q <= 1'b0;
      filt_rst_q <= 1'b0;
    end
    else if (wr_aud_ctrl)
    begin
      aud_intv_q <= reg_wdata[AUD_INTV_LSB +: 2];
      eng_ofs_q  <= reg_wdata[ENG_OFS_LSB +: 4];
      gain_en_q  <= reg_wdata[BIT_GAIN_EN];
      gain_q     <= reg_wdata[GAIN_LSB +: 5];
      hp_en_q    <= reg_wdata[BIT_HIGHPASS];
      decim_en_q <= reg_wdata[BIT_DECIM_EN];
      filt_rst_q <= reg_wdata[BIT_FILT_RST];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gain_path_enable_q <= 1'b0;
      record_gain_db_q   <= 5'h00;
      highpass_enable_q  <= 1'b0;
      decim_enable_q     <= 1'b0;
      filter_reset_q     <= 1'b0;
    end
    else
    begin
      gain_path_enable_q <= gain_en_q;
      record_gain_db_q   <= gain_q;
      highpass_enable_q  <= hp_en_q;
      decim_enable_q     <= decim_en_q;
      filter_reset_q     <= filt_rst_q;
    end
  end

  // Sample ring: slot order is recording order, restarting at slot 0
  always_ff @(posedge clk)
  begin
    if (!rst_n || !rec_active)
    begin
      wr_ptr_q  <= 3'h0;
      aud_cnt_q <= 4'h0;
    end
    else if (aud_take)
    begin
      wr_ptr_q  <= wr_ptr_q + 3'h1;
      aud_cnt_q <= aud_intv_hit ? 4'h0 : aud_cnt_q + 4'h1;
    end
  end

  for (genvar s = 0; s < SAMPLE_SLOTS; s++)
  begin : g_slot
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        samples_q[s] <= '0;
      else if (aud_take && (wr_ptr_q == 3'(s)))
        samples_q[s] <= rec_sample;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      aud_irq_q <= 1'b0;
    else if (aud_intv_hit)
      aud_irq_q <= 1'b1;
    else if (wr_aud_ctrl && !reg_wdata[BIT_AUD_IRQ])
      aud_irq_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= (det_irq_q && det_irq_en_q)
               || ((conv_irq_q || aud_irq_q) && conv_irq_en_q);
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = RESET_WORD;
    case (reg_addr)
      OFS_CONV_CTRL:
      begin
        rd_word[BIT_DET_IRQ_EN]  = det_irq_en_q;
        rd_word[BIT_CONV_IRQ_EN] = conv_irq_en_q;
        rd_word[BIT_DET_IRQ]     = det_irq_q;
        rd_word[BIT_CONV_IRQ]    = conv_irq_q;
        rd_word[BIT_CONV_EN]     = conv_en_q;
        rd_word[BIT_CONV_RST]    = conv_rst_q;
        rd_word[BIT_CONV_START]  = start_q;
        rd_word[BIT_RESTART_RD]  = restart_rd_q;
        rd_word[CHAN_LSB +: 3]   = chan_q;
        rd_word[BIT_FINISH]      = finish_q;
      end
      OFS_CONV_RESULT: rd_word[RESULT_W-1:0] = result_q;
      OFS_DET_CTRL:
      begin
        rd_word[BIT_DET_EN] = det_en_q;
        rd_word[2:0]        = tap_q;
      end
      OFS_DET_STATUS:  rd_word[0] = det_en_q && detector_below_ref;
      OFS_AUDIO_CTRL:
      begin
        rd_word[AUD_INTV_LSB +: 2] = aud_intv_q;
        rd_word[ENG_OFS_LSB +: 4]  = eng_ofs_q;
        rd_word[BIT_AUD_IRQ]       = aud_irq_q;
        rd_word[BIT_GAIN_EN]       = gain_en_q;
        rd_word[GAIN_LSB +: 5]     = gain_q;
        rd_word[BIT_HIGHPASS]      = hp_en_q;
        rd_word[BIT_DECIM_EN]      = decim_en_q;
        rd_word[BIT_FILT_RST]      = filt_rst_q;
      end
      OFS_AUDIO_SAMPLE_BUFFER_0:  rd_word = {samples_q[1], samples_q[0]};
      OFS_AUDIO_SAMPLE_BUFFER_1:  rd_word = {samples_q[3], samples_q[2]};
      OFS_AUDIO_SAMPLE_BUFFER_2:  rd_word = {samples_q[5], samples_q[4]};
      OFS_AUDIO_BUF3:  rd_word = {samples_q[7], samples_q[6]};
      default:         rd_word = RESET_WORD;
    endcase
  end

  // Data stand for exactly one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata_q <= RESET_WORD;
    else
      reg_rdata_q <= reg_rd ? rd_word : RESET_WORD;
  end

endmodule

`default_nettype wire

// [rtl/alr_pkg.sv]
// Purpose: Shared constants for the converter, detector and audio record controller
// Assumes: 32-bit register port, byte addresses, 250 MHz system clock
// Notes:   Offsets are byte addresses of aligned words
`default_nettype none

package alr_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CONV_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONV_RESULT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DET_CTRL    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DET_STATUS  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_CTRL  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_SAMPLE_BUFFER_0  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_SAMPLE_BUFFER_1  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_SAMPLE_BUFFER_2  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_AUDIO_BUF3  = 8'h2c;
  localparam logic [31:0]       RESET_WORD      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Converter control fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_DET_IRQ_EN   = 22;
  localparam int unsigned BIT_CONV_IRQ_EN  = 21;
  localparam int unsigned BIT_DET_IRQ      = 19;
  localparam int unsigned BIT_CONV_IRQ     = 18;
  localparam int unsigned BIT_CONV_EN      = 17;
  localparam int unsigned BIT_CONV_RST     = 16;
  localparam int unsigned BIT_CONV_START   = 13;
  localparam int unsigned BIT_RESTART_RD   = 12;
  localparam int unsigned CHAN_LSB         = 9;
  localparam int unsigned BIT_FINISH       = 0;
  localparam int unsigned RESULT_W         = 10;
  localparam logic [2:0]  CHAN_AUDIO_PAIR  = 3'h0;

  // ----------------------------------------------------------------
  // Detector fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_DET_EN       = 3;
  localparam int unsigned DET_TAPS         = 8;

  // ----------------------------------------------------------------
  // Audio control fields
  // ----------------------------------------------------------------
  localparam int unsigned AUD_INTV_LSB     = 30;
  localparam int unsigned ENG_OFS_LSB      = 26;
  localparam int unsigned BIT_AUD_IRQ      = 9;
  localparam int unsigned BIT_GAIN_EN      = 8;
  localparam int unsigned GAIN_LSB         = 3;
  localparam int unsigned BIT_HIGHPASS     = 2;
  localparam int unsigned BIT_DECIM_EN     = 1;
  localparam int unsigned BIT_FILT_RST     = 0;
  localparam int unsigned SAMPLE_W         = 16;
  localparam int unsigned SAMPLE_SLOTS     = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CONV_CLK_MAX_MHZ = 25;
  // Least converter clock period, rounded up to whole system cycles
  localparam int unsigned CONV_DIV_DEF     = (CLK_MHZ + CONV_CLK_MAX_MHZ - 1) / CONV_CLK_MAX_MHZ;
  localparam int unsigned CONV_CYCLES      = 50;

endpackage

`default_nettype wire

// [bench/alr_ctrl_asserts.sv]
// Purpose: Port checks for alr_ctrl
// Assumes: One clock domain, bound to every alr_ctrl
// Notes:   Converter clock rises counted per conversion
`default_nettype none
module alr_ctrl_asserts
  import alr_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata_q,
  input wire logic                irq_q,
  input wire logic                conv_enable_q,
  input wire logic                conv_clk_q,
  input wire logic                conv_start_q,
  input wire logic                detector_enable_q,
  input wire logic [DET_TAPS-1:0] detector_switch_q,
  input wire logic                detector_below_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  logic [7:0] edges_q;
  wire        wr_det = reg_wr && reg_addr == OFS_DET_CTRL;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Reset to 50 and counting on past 50, so a stray clock outside a conversion fails
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      edges_q <= 8'h32;
    else if (conv_start_q)
      edges_q <= {7'h0, conv_clk_q};
    else if ($rose(conv_clk_q))
      edges_q <= edges_q + 8'h01;
  end
  property p_onehot; $past(rst_n) |-> $onehot(detector_switch_q); endproperty
  // Pins sit two registers behind the write
  property p_tap; wr_det |=> ##1 detector_switch_q == 8'h01 << $past(reg_wdata[2:0], 2); endproperty
  property p_det_en; wr_det |=> ##1 detector_enable_q == $past(reg_wdata[3], 2); endproperty
  property p_conv_en;
    reg_wr && reg_addr == OFS_CONV_CTRL |=> ##1 conv_enable_q == $past(reg_wdata[17], 2);
  endproperty
  property p_res_hi; reg_rd && reg_addr == OFS_CONV_RESULT |=> reg_rdata_q[31:10] == 22'h0; endproperty
  property p_det_sts;
    reg_rd && reg_addr == OFS_DET_STATUS |=> reg_rdata_q == {31'h0, $past(detector_enable_q && detector_below_ref)};
  endproperty
  property p_irq_off;
    reg_wr && reg_addr == OFS_CONV_CTRL && reg_wdata[22:21] == 2'b00 |=> ##1 !irq_q;
  endproperty
  property p_clk_cnt; $rose(conv_clk_q) && !conv_start_q |-> edges_q < 8'h32; endproperty
  a_onehot: assert property (p_onehot) else $error("tap switches not one-hot");
  a_tap: assert property (p_tap) else $error("wrong tap switch closed");
  a_det_en: assert property (p_det_en) else $error("detector enable not copied");
  a_conv_en: assert property (p_conv_en) else $error("converter enable not copied");
  a_res_hi: assert property (p_res_hi) else $error("result upper bits set");
  a_det_sts: assert property (p_det_sts) else $error("detector status wrong");
  a_irq_off: assert property (p_irq_off) else $error("interrupt with enables off");
  a_clk_cnt: assert property (p_clk_cnt) else $error("over 50 converter clocks");
  c_start: cover property (conv_start_q);
  c_irq: cover property ($rose(irq_q));
  c_tap7: cover property (detector_switch_q[7]);
endmodule
bind alr_ctrl alr_ctrl_asserts u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_q, .irq_q, .conv_enable_q, .conv_clk_q, .conv_start_q, .detector_enable_q,
  .detector_switch_q, .detector_below_ref);
`default_nettype wire

// [bench/alr_analog_model.sv]
// Purpose: Behavioural converter and detector macro
// Assumes: Result ready after 45 converter clocks
// Notes:   One sample every 16 cycles while recording
`default_nettype none
module alr_analog_model
  import alr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                conv_clk_q,
  input  wire logic                conv_start_q,
  input  wire logic [2:0]          conv_channel_q,
  input  wire logic [DET_TAPS-1:0] detector_switch_q,
  input  wire logic                decim_enable_q,
  input  wire logic                filter_reset_q,
  output logic      [RESULT_W-1:0] conv_data,
  output logic                     detector_below_ref,
  output logic                     rec_sample_valid,
  output logic      [SAMPLE_W-1:0] rec_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  n_q   = 8'h0;
  logic [3:0]  ph_q  = 4'h0;
  logic [11:0] seq_q = 12'h0;
  wire         act   = decim_enable_q && !filter_reset_q;
  always @(posedge clk)
  begin
    n_q <= conv_start_q ? 8'h0 : n_q + 8'(conv_clk_q && n_q < 8'h32);
    ph_q <= act ? ph_q + 4'h1 : 4'h0;
    seq_q <= act ? seq_q + 12'(rec_sample_valid) : 12'h0;
  end
  // Not settled until late in the conversion
  assign conv_data = n_q > 8'h2c ? {conv_channel_q, 7'h2b} : {5{ph_q[0], ~ph_q[0]}};
  assign detector_below_ref = |detector_switch_q[7:4];
  assign rec_sample_valid = act && ph_q == 4'hf;
  assign rec_sample = rec_sample_valid ? {4'ha, seq_q} : {16{ph_q[0]}};
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Purpose: Register-level test of alr_ctrl
// Assumes: Converter divider set to 2
// Notes:   Waits are bounded
`default_nettype none
module testbench
  import alr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h want %h", $time, g, e); end end
  // ----------------------------------------
  // Signals, design and far side
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata_q;
  logic irq_q, conv_clk_q, conv_start_q, decim_enable_q, filter_reset_q, detector_below_ref, rec_sample_valid;
  logic conv_enable_q, conv_reset_q, gain_path_enable_q, highpass_enable_q;
  logic [4:0] record_gain_db_q;
  logic [2:0] conv_channel_q;
  logic [DET_TAPS-1:0] detector_switch_q;
  logic [RESULT_W-1:0] conv_data;
  logic [SAMPLE_W-1:0] rec_sample;
  int mismatches = 0, n_tests = 0, n_starts = 0, s;
  always #2 clk = ~clk;
  always @(posedge clk) if (conv_start_q === 1'b1) n_starts <= n_starts + 1;
  alr_ctrl #(.CONV_DIV(2)) u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .irq_q, .conv_enable_q, .conv_reset_q, .conv_clk_q, .conv_start_q, .conv_channel_q, .conv_data,
    .detector_enable_q(), .detector_switch_q, .detector_below_ref, .gain_path_enable_q,
    .record_gain_db_q, .highpass_enable_q, .decim_enable_q, .filter_reset_q, .rec_sample_valid, .rec_sample);
  alr_analog_model u_ana (.clk, .conv_clk_q, .conv_start_q, .conv_channel_q, .detector_switch_q,
    .decim_enable_q, .filter_reset_q, .conv_data, .detector_below_ref, .rec_sample_valid, .rec_sample);
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    `CHK(reg_rdata_q, e)
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 400 && irq_q !== 1'b1; i++) @(posedge clk);
    if (i == 400)
    begin
      mismatches++;
      results();
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i) + (i > 0 ? 8'h8 : 8'h0) + (i > 4 ? 8'h8 : 8'h0), 32'h0);
    $display("reset test done");
    for (int t = 0; t < 8; t++)
    begin
      wr(OFS_DET_CTRL, 32'h8 | 32'(t));
      rd(OFS_DET_STATUS, {31'h0, t > 3});
      `CHK(detector_switch_q, 8'h01 << t)
    end
    rd(OFS_CONV_CTRL, 32'h0008_0000);
    wr(OFS_CONV_CTRL, 32'h0048_0000);
    repeat (2) @(posedge clk);
    `CHK(irq_q, 1'b1)
    wr(OFS_DET_CTRL, 32'h0);
    wr(OFS_CONV_CTRL, 32'h0040_0000);
    rd(OFS_CONV_CTRL, 32'h0040_0000);
    `CHK(irq_q, 1'b0)
    $display("detector test done");
    for (int c = 2; c < 8; c++)
    begin
      wr(OFS_CONV_CTRL, 32'h0022_2000 | 32'(c) << 9);
      rd(OFS_CONV_CTRL, 32'h0022_2000 | 32'(c) << 9);
      wait_irq();
      rd(OFS_CONV_CTRL, 32'h0026_0001 | 32'(c) << 9);
      rd(OFS_CONV_RESULT, {22'h0, 3'(c), 7'h2b});
      wr(OFS_CONV_CTRL, 32'h0022_0000 | 32'(c) << 9);
    end
    wr(OFS_CONV_CTRL, 32'h0022_1e00);
    rd(OFS_CONV_RESULT, 32'h0000_03ab);
    wait_irq();
    rd(OFS_CONV_CTRL, 32'h0026_1e01);
    wr(OFS_CONV_CTRL, 32'h0);
    rd(OFS_CONV_RESULT, 32'h0000_03ab);
    $display("conversion test done");
    wr(OFS_CONV_CTRL, 32'h0022_0e00);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_AUDIO_CTRL, 32'h0);
      wr(OFS_AUDIO_CTRL, 32'(m) << 30 | 32'h102);
      repeat ((16 << m) - 8) @(posedge clk);
      rd(OFS_AUDIO_CTRL, 32'(m) << 30 | 32'h102);
      repeat (12) @(posedge clk);
      rd(OFS_AUDIO_CTRL, 32'(m) << 30 | 32'h302);
      `CHK(irq_q, 1'b1)
    end
    for (int n = 0; n < 4; n++) rd(OFS_AUDIO_SAMPLE_BUFFER_0 + 8'(4 * n), {4'ha, 12'(2 * n + 1), 4'ha, 12'(2 * n)});
    `CHK(conv_channel_q, 3'h0)
    s = n_starts;
    wr(OFS_CONV_CTRL, 32'h0022_2e00);
    repeat (150) @(posedge clk);
    `CHK(n_starts, s)
    wr(OFS_AUDIO_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    wait_irq();
    rd(OFS_CONV_CTRL, 32'h0026_0e01);
    $display("audio test done");
    wr(OFS_AUDIO_CTRL, 32'h0000_01ad);
    wr(OFS_CONV_CTRL, 32'h0001_0000);
    rd(OFS_AUDIO_CTRL, 32'h0000_01ad);
    `CHK({conv_enable_q, conv_reset_q, decim_enable_q, filter_reset_q}, 4'h5)
    `CHK({gain_path_enable_q, record_gain_db_q, highpass_enable_q}, 7'h6b)
    $display("pin test done");
    results();
  end
endmodule
`default_nettype wire
